// File: src/dma_link_engine.sv
`timescale 1ns/1ps
`include "dma_link_consts.svh"

module dma_link_engine
  import dma_link_pkg::*;
(
  // Clock and reset
  input wire logic   hclk,
  input wire logic   hresetn,
  // Host side
  dma_link_if.device lnk
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  word_t      pm_mem [0:`PM_WORDS-1];
  word_t      act_q  [0:`NUM_CH-1][0:`SET_WORDS-1];
  eng_state_t state_q;
  logic       cur_ch_q;
  logic [3:0] cnt_q;
  logic [6:0] link_set_q;
  word_t      rd_data_q;
  logic [1:0] ev_pend_q;
  word_t      pend_q;
  logic       move_valid_q;
  logic       move_chan_q;
  word_t      move_src_q;
  word_t      move_dst_q;
  logic [15:0] move_bytes_q;

  // ----------------------------------------------------------------
  // Decode and selection
  // ----------------------------------------------------------------
  logic        pm_hit;
  logic [6:0]  pm_set;
  logic [2:0]  pm_word;
  logic [9:0]  rd_idx;
  logic [1:0]  ev_in;
  logic [1:0]  serve_clr;
  logic        serve_en;
  logic        serve_ch;
  word_t       sel_opt;
  word_t       sel_cnt;
  word_t       sel_bidx;
  logic [15:0] sel_link;
  logic [15:0] sel_bcnt;
  logic [5:0]  sel_tcc;
  logic        do_move;
  logic        block_done;
  logic        do_link;
  word_t       pend_set;

  function automatic logic [6:0] chan_set(input logic ch);
    chan_set = ch ? `SET_TX : `SET_RX;
  endfunction : chan_set

  always_comb
  begin
    pm_hit   = lnk.pm_we && (lnk.pm_addr[15:12] == `PM_REGION);
    pm_set   = lnk.pm_addr[11:5];
    pm_word  = lnk.pm_addr[4:2];
    rd_idx   = {link_set_q, cnt_q[2:0]};
    ev_in    = {lnk.tx_event, lnk.rx_event};
    // Receive first: its source overruns if left waiting
    serve_en = (state_q == ST_IDLE) && (|ev_pend_q);
    serve_ch = ~ev_pend_q[0];
    sel_opt  = act_q[serve_ch][`W_OPT];
    sel_cnt  = act_q[serve_ch][`W_CNT];
    sel_bidx = act_q[serve_ch][`W_BIDX];
    sel_link = act_q[serve_ch][`W_LINK][15:0];
    sel_bcnt = sel_cnt[31:16];
    sel_tcc  = sel_opt[`OPT_TCC_MSB:`OPT_TCC_LSB];
    do_move    = serve_en && (sel_bcnt != 16'h0000);
    block_done = do_move && (sel_bcnt == `CNT_STEP);
    do_link    = block_done && (sel_link != `LINK_NULL);
    serve_clr  = 2'b00;
    if (serve_en)
    begin
      serve_clr[serve_ch] = 1'b1;
    end
    pend_set = 32'h0000_0000;
    if (block_done && sel_opt[`OPT_COMPLETION_IRQ_ENABLE] && !sel_tcc[`TCC_HI_BIT])
    begin
      pend_set[sel_tcc[4:0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Parameter memory
  // ----------------------------------------------------------------
  always_ff @(posedge hclk)
  begin
    if (pm_hit)
    begin
      pm_mem[{pm_set, pm_word}] <= lnk.pm_wdata;
    end
    rd_data_q <= pm_mem[rd_idx];
  end

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  // Events held while reloading are served once the set is whole
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ev_pend_q <= 2'b00;
    end
    else
    begin
      ev_pend_q <= (ev_pend_q & ~serve_clr) | ev_in;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q    <= ST_IDLE;
      cur_ch_q   <= 1'b0;
      cnt_q      <= 4'h0;
      link_set_q <= 7'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (do_link)
          begin
            state_q    <= ST_RELOAD;
            cur_ch_q   <= serve_ch;
            cnt_q      <= 4'h0;
            link_set_q <= sel_link[11:5];
          end
        end
        ST_RELOAD:
        begin
          if (cnt_q == `W_LAST)
          begin
            state_q <= ST_IDLE;
          end
          else
          begin
            cnt_q <= 4'(cnt_q + 4'h1);
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Active sets
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < `NUM_CH; c++)
      begin
        for (int w = 0; w < `SET_WORDS; w++)
        begin
          act_q[c][w] <= 32'h0000_0000;
        end
      end
    end
    else if ((state_q == ST_RELOAD) && (cnt_q != 4'h0))
    begin
      act_q[cur_ch_q][3'(cnt_q - 4'h1)] <= rd_data_q;
    end
    else if (do_move)
    begin
      act_q[serve_ch][`W_SRC] <= 32'(act_q[serve_ch][`W_SRC] +
                                {{16{sel_bidx[15]}}, sel_bidx[15:0]});
      act_q[serve_ch][`W_DST] <= 32'(act_q[serve_ch][`W_DST] +
                                {{16{sel_bidx[31]}}, sel_bidx[31:16]});
      act_q[serve_ch][`W_CNT] <= {16'(sel_bcnt - `CNT_STEP),
                                  sel_cnt[15:0]};
    end
    else
    begin
      // Direct programming of a channel's own set; a clash with a
      // move in the same cycle loses the write
      for (int c = 0; c < `NUM_CH; c++)
      begin
        if (pm_hit && (pm_set == chan_set(1'(c))))
        begin
          act_q[c][pm_word] <= lnk.pm_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Element move output
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      move_valid_q <= 1'b0;
      move_chan_q  <= 1'b0;
      move_src_q   <= 32'h0000_0000;
      move_dst_q   <= 32'h0000_0000;
      move_bytes_q <= 16'h0000;
    end
    else
    begin
      move_valid_q <= do_move;
      if (do_move)
      begin
        move_chan_q  <= serve_ch;
        move_src_q   <= act_q[serve_ch][`W_SRC];
        move_dst_q   <= act_q[serve_ch][`W_DST];
        move_bytes_q <= sel_cnt[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion pending
  // ----------------------------------------------------------------
  // A completion in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= 32'h0000_0000;
    end
    else
    begin
      pend_q <= (pend_q & ~lnk.pend_clr) | pend_set;
    end
  end

  assign lnk.pend        = pend_q;
  assign lnk.move_valid  = move_valid_q;
  assign lnk.move_chan   = move_chan_q;
  assign lnk.move_src    = move_src_q;
  assign lnk.move_dst    = move_dst_q;
  assign lnk.move_bytes  = move_bytes_q;
  assign lnk.reload_busy = (state_q == ST_RELOAD);

endmodule : dma_link_engine

// File: src/dma_link_consts.svh
`ifndef DMA_LINK_CONSTS_SVH
`define DMA_LINK_CONSTS_SVH

// ----------------------------------------------------------------
// Parameter memory layout
// ----------------------------------------------------------------
`define PM_REGION     4'h4
`define PM_SETS       128
`define SET_WORDS     8
`define PM_WORDS      1024
`define NUM_CH        2
`define SET_RX        7'h03
`define SET_TX        7'h02

// ----------------------------------------------------------------
// Word positions inside one set
// ----------------------------------------------------------------
`define W_OPT         3'h0
`define W_SRC         3'h1
`define W_CNT         3'h2
`define W_DST         3'h3
`define W_BIDX        3'h4
`define W_LINK        3'h5
`define W_LAST        4'h8

// ----------------------------------------------------------------
// Options word fields
// ----------------------------------------------------------------
`define OPT_COMPLETION_IRQ_ENABLE   20
`define OPT_TCC_MSB   17
`define OPT_TCC_LSB   12
`define TCC_HI_BIT    5
`define LINK_NULL     16'hffff
`define CNT_STEP      16'h0001

// ----------------------------------------------------------------
// Host register offsets
// ----------------------------------------------------------------
`define A_PM_ADDR     8'h00
`define A_PM_DATA     8'h04
`define A_PEND        8'h08
`define A_EVT         8'h0c
`define A_IRQ_STAT    8'h10
`define A_IRQ_MASK    8'h14
`define A_MOVES       8'h18
`define A_BUSY        8'h1c
`define EVT_RX_BIT    0
`define EVT_TX_BIT    1
`define PM_ADDR_STEP  16'h0004
`define MOVE_STEP     32'h0000_0001

`endif

// File: src/dma_link_pkg.sv
package dma_link_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic {
    ST_IDLE,
    ST_RELOAD
  } eng_state_t;

endpackage : dma_link_pkg

// File: src/dma_link_if.sv
`timescale 1ns/1ps
interface dma_link_if;
  // Parameter memory write port
  logic        pm_we;
  logic [15:0] pm_addr;
  logic [31:0] pm_wdata;
  // Completion pending
  logic [31:0] pend;
  logic [31:0] pend_clr;
  // Element events
  logic        rx_event;
  logic        tx_event;
  // Element moves
  logic        move_valid;
  logic        move_chan;
  logic [31:0] move_src;
  logic [31:0] move_dst;
  logic [15:0] move_bytes;
  logic        reload_busy;

  modport device (
    input  pm_we, pm_addr, pm_wdata, pend_clr, rx_event, tx_event,
    output pend, move_valid, move_chan, move_src, move_dst,
    output move_bytes, reload_busy
  );

  modport other (
    output pm_we, pm_addr, pm_wdata, pend_clr, rx_event, tx_event,
    input  pend, move_valid, move_chan, move_src, move_dst,
    input  move_bytes, reload_busy
  );
endinterface : dma_link_if

// File: src/dma_link_host.sv
`timescale 1ns/1ps
`include "dma_link_consts.svh"

module dma_link_host
  import dma_link_pkg::*;
(
  // Clock and reset
  input wire logic   hclk,
  input wire logic   hresetn,
  // AHB-Lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  output logic            hreadyout,
  output logic            hresp,
  output logic [31:0]     hrdata,
  // Interrupt
  output logic            irq,
  // Engine side
  dma_link_if.other  lnk
);

  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  logic        take;
  logic        wr_q;
  logic [7:0]  addr_q;
  word_t       hrdata_q;
  word_t       rd_mux;
  logic [15:0] pm_addr_q;
  logic        pm_we_q;
  logic [15:0] pm_waddr_q;
  word_t       pm_wdata_q;
  word_t       pend_clr_q;
  logic        rx_ev_q;
  logic        tx_ev_q;
  word_t       pend_prev_q;
  word_t       stat_q;
  word_t       mask_q;
  word_t       moves_q;
  logic        wr_stat;

  // Size is ignored: only whole words are ever issued
  assign take    = hsel && hready && htrans[1];
  assign wr_stat = wr_q && (addr_q == `A_IRQ_STAT);

  always_comb
  begin
    case (haddr[7:0])
      `A_PM_ADDR:  rd_mux = {16'h0000, pm_addr_q};
      `A_PEND:     rd_mux = lnk.pend;
      `A_IRQ_STAT: rd_mux = stat_q;
      `A_IRQ_MASK: rd_mux = mask_q;
      `A_MOVES:    rd_mux = moves_q;
      `A_BUSY:     rd_mux = {31'h0000_0000, lnk.reload_busy};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= take && hwrite;
      if (take)
      begin
        addr_q <= haddr[7:0];
      end
      if (take && !hwrite)
      begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write side effects
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pm_addr_q  <= 16'h0000;
      pm_we_q    <= 1'b0;
      pm_waddr_q <= 16'h0000;
      pm_wdata_q <= 32'h0000_0000;
      pend_clr_q <= 32'h0000_0000;
      rx_ev_q    <= 1'b0;
      tx_ev_q    <= 1'b0;
      mask_q     <= 32'h0000_0000;
    end
    else
    begin
      pm_we_q    <= 1'b0;
      pend_clr_q <= 32'h0000_0000;
      rx_ev_q    <= 1'b0;
      tx_ev_q    <= 1'b0;
      if (wr_q)
      begin
        case (addr_q)
          `A_PM_ADDR: pm_addr_q <= hwdata[15:0];
          `A_PM_DATA:
          begin
            // Auto-increment lets a whole set go in eight writes
            pm_we_q    <= 1'b1;
            pm_waddr_q <= pm_addr_q;
            pm_wdata_q <= hwdata;
            pm_addr_q  <= 16'(pm_addr_q + `PM_ADDR_STEP);
          end
          `A_PEND:     pend_clr_q <= hwdata;
          `A_EVT:
          begin
            rx_ev_q <= hwdata[`EVT_RX_BIT];
            tx_ev_q <= hwdata[`EVT_TX_BIT];
          end
          `A_IRQ_MASK: mask_q <= hwdata;
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and move count
  // ----------------------------------------------------------------
  // A new completion in the clearing cycle stays set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_prev_q <= 32'h0000_0000;
      stat_q      <= 32'h0000_0000;
      moves_q     <= 32'h0000_0000;
    end
    else
    begin
      pend_prev_q <= lnk.pend;
      stat_q      <= (stat_q & ~(wr_stat ? hwdata : 32'h0000_0000)) |
                     (lnk.pend & ~pend_prev_q);
      if (lnk.move_valid)
      begin
        moves_q <= 32'(moves_q + `MOVE_STEP);
      end
    end
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = hrdata_q;
  assign irq          = |(stat_q & mask_q);
  assign lnk.pm_we    = pm_we_q;
  assign lnk.pm_addr  = pm_waddr_q;
  assign lnk.pm_wdata = pm_wdata_q;
  assign lnk.pend_clr = pend_clr_q;
  assign lnk.rx_event = rx_ev_q;
  assign lnk.tx_event = tx_ev_q;

endmodule : dma_link_host

// File: testbench/dma_link_monitor.sv
`timescale 1ns/1ps
module dma_link_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Link signals
  input wire logic [31:0] pend,
  input wire logic [31:0] pend_clr,
  input wire logic        move_valid,
  input wire logic        move_chan,
  input wire logic        reload_busy
);
  // ------------
  // Link checks
  // ------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_pend_sticky: assert property (
    1 |=> (pend & $past(pend & ~pend_clr)) == $past(pend & ~pend_clr))
    else $error("pending bit dropped");
  a_pend_clear: assert property (
    |pend_clr |=> ((pend & $past(pend_clr)) == 32'h0) || move_valid)
    else $error("pending bit not cleared");
  a_pend_cause: assert property (
    (pend & ~$past(pend)) != 32'h0 |-> move_valid)
    else $error("pending bit set without a move");
  a_pend_index: assert property (
    (pend & ~$past(pend)) != 32'h0 |->
      (pend & ~$past(pend)) == (move_chan ? 32'h4 : 32'h8))
    else $error("wrong pending bit");
  a_reload_len: assert property (
    $rose(reload_busy) |->
      reload_busy [*8] ##1 reload_busy ##1 !reload_busy)
    else $error("reload length wrong");
  a_reload_cause: assert property (
    $rose(reload_busy) |-> move_valid)
    else $error("reload without a final move");
  a_reload_quiet: assert property (
    reload_busy && $past(reload_busy) |-> !move_valid)
    else $error("move during reload");
  a_move_single: assert property (
    move_valid |=> !(move_valid && move_chan == $past(move_chan)))
    else $error("one event moved twice");
endmodule : dma_link_monitor

// File: testbench/dma_link_pingpong_reload_tb.sv
`timescale 1ns/1ps
`include "dma_link_consts.svh"
module dma_link_pingpong_reload_tb
  import dma_link_pkg::*;
;
  // ------------
  // Bench signals
  // ------------
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  word_t       hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  word_t       hrdata;
  logic        irq;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  word_t       q_src[$];
  word_t       q_dst[$];
  logic        q_ch[$];

  dma_link_if lnk_if ();

  dma_link_engine dma_link_engine_inst (.hclk(hclk), .hresetn(hresetn),
    .lnk(lnk_if));
  dma_link_host dma_link_host_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .lnk(lnk_if));
  dma_link_monitor dma_link_monitor_inst (.hclk(hclk), .hresetn(hresetn),
    .pend(lnk_if.pend), .pend_clr(lnk_if.pend_clr),
    .move_valid(lnk_if.move_valid), .move_chan(lnk_if.move_chan),
    .reload_busy(lnk_if.reload_busy));

  always #12.5 hclk = ~hclk;

  // Moves are one-cycle pulses, so capture them at every edge
  always @(posedge hclk)
    if (hresetn && lnk_if.move_valid === 1'b1)
    begin
      chk_w({16'h0, lnk_if.move_bytes}, 32'h1);
      q_src.push_back(lnk_if.move_src);
      q_dst.push_back(lnk_if.move_dst);
      q_ch.push_back(lnk_if.move_chan);
    end

  // ------------
  // Tasks
  // ------------
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk_w(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b

  // Entered at a rising edge; read data taken at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input word_t wd,
                      output word_t rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input word_t wd);
    word_t d;
    xfer(1'b1, a, wd, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input word_t exp);
    word_t d;
    xfer(1'b0, a, 32'h0, d);
    chk_w(d, exp);
  endtask : rd_chk

  task automatic wait_rd(input logic [7:0] a, input word_t exp);
    word_t d;
    int    n;
    n = 0;
    do
    begin
      xfer(1'b0, a, 32'h0, d);
      n++;
    end
    while (d !== exp && n < 60);
    chk_w(d, exp);
  endtask : wait_rd

  // Whole set: four elements per block, one block per set
  task automatic set_wr(input logic [15:0] off, input word_t channel_options_word, src,
                        input word_t dst, bidx, link);
    word_t v[8];
    v = '{channel_options_word, src, 32'h0004_0001, dst, bidx, link, 32'h0, 32'h1};
    wr(`A_PM_ADDR, {16'h0, off});
    foreach (v[i]) wr(`A_PM_DATA, v[i]);
  endtask : set_wr

  // Rx and tx moves checked per channel against the block's buffer
  task automatic chk_moves(input word_t rx_dst, input word_t tx_src);
    word_t kr;
    word_t kt;
    kr = 32'h0;
    kt = 32'h0;
    foreach (q_ch[i])
      if (q_ch[i] === 1'b0)
      begin
        chk_w(q_src[i], 32'h01d0_0000);
        chk_w(q_dst[i], rx_dst + kr);
        kr++;
      end
      else
      begin
        chk_w(q_src[i], tx_src + kt);
        chk_w(q_dst[i], 32'h01d0_0004);
        kt++;
      end
    chk_w(kr + kt, 32'h8);
    q_src.delete();
    q_dst.delete();
    q_ch.delete();
  endtask : chk_moves

  // Hang guard: the full sequence needs well under this
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  // ------------
  // Main sequence
  // ------------
  logic [15:0] off_t[6] = '{16'h4060, 16'h4800, 16'h4820,
                            16'h4040, 16'h4840, 16'h4860};
  logic [15:0] lnk_t[6] = '{16'h4800, 16'h4820, 16'h4800,
                            16'h4840, 16'h4860, 16'h4840};
  logic [15:0] buf_t[6] = '{16'h0000, 16'h0800, 16'h0000,
                            16'h1000, 16'h1800, 16'h1000};
  word_t       nopt[2] = '{32'h0000_3000, 32'h0012_8000};

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk_b(hresp, 1'b0);
    rd_chk(`A_PEND, 32'h0);
    rd_chk(`A_IRQ_STAT, 32'h0);
    rd_chk(`A_MOVES, 32'h0);
    rd_chk(`A_BUSY, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      set_wr(off_t[i], 32'h0010_3000, 32'h01d0_0000,
             {16'h1180, buf_t[i]}, 32'h0001_0000, {16'h0004, lnk_t[i]});
      set_wr(off_t[i+3], 32'h0010_2000, {16'h1180, buf_t[i+3]},
             32'h01d0_0004, 32'h0000_0001, {16'h0004, lnk_t[i+3]});
    end
    wr(`A_IRQ_MASK, 32'h8);
    for (int b = 0; b < 3; b++)
    begin
      repeat (4) wr(`A_EVT, 32'h3);
      wait_rd(`A_PEND, 32'hc);
      wait_rd(`A_BUSY, 32'h0);
      rd_chk(`A_PEND, 32'hc);
      chk_moves(b[0] ? 32'h1180_0800 : 32'h1180_0000,
                b[0] ? 32'h1180_1800 : 32'h1180_1000);
      if (b == 0)
      begin
        rd_chk(`A_IRQ_STAT, 32'hc);
        chk_b(irq, 1'b1);
        wr(`A_IRQ_STAT, 32'h8);
        rd_chk(`A_IRQ_STAT, 32'h4);
        chk_b(irq, 1'b0);
        wr(`A_IRQ_MASK, 32'hc);
        rd_chk(`A_IRQ_MASK, 32'hc);
        chk_b(irq, 1'b1);
        wr(`A_IRQ_STAT, 32'h4);
        rd_chk(`A_IRQ_STAT, 32'h0);
        chk_b(irq, 1'b0);
      end
      wr(`A_PEND, 32'hc);
      // Clear pulse reaches the pending bits one edge after the write
      @(posedge hclk);
      rd_chk(`A_PEND, 32'h0);
    end
    rd_chk(`A_MOVES, 32'd24);
    // Enable off, then a code beyond the pending width
    foreach (nopt[i])
    begin
      set_wr(16'h4060, nopt[i], 32'h01d0_0000, 32'h1180_0000,
             32'h0001_0000, 32'h0004_ffff);
      repeat (4) wr(`A_EVT, 32'h1);
      wait_rd(`A_MOVES, 32'd28 + 32'd4 * i);
      rd_chk(`A_PEND, 32'h0);
      rd_chk(`A_BUSY, 32'h0);
    end
    // Stopped channel drops its events
    wr(`A_EVT, 32'h1);
    repeat (4) wr(`A_EVT, 32'h0);
    rd_chk(`A_MOVES, 32'd32);
    test_done();
  end
endmodule : dma_link_pingpong_reload_tb
